// file: rtl/serializer_id_reset.v
// I2C slave port with the target-address register and self-clearing soft-reset register
// How it works
// - Address field loads strap, software-writable.
// - Select bit picks strap or programmed address.
// - Bit 4 pulses video-input reset, self-clears.
// - Bit 1 resets whole core and registers.
// - Bit 0 resets core, registers mostly kept.
// - Keep-register reset reloads strap-derived values.
// - Keep-register reset restores listed registers too.
// - Strap address 0x0C..0x1A in steps of two.
`timescale 1ns/1ps
`include "serializer_id_reset_defines.vh"

module serializer_id_reset #(
  parameter RST_PULSE_CYCLES = `RST_PULSE_CYCLES
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       scl,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe,
  input  wire [2:0] address_strap_pin,
  output reg  [6:0] active_address,
  output wire       video_input_reset,
  output wire       full_core_reset,
  output wire       core_reset_keep_registers,
  output reg        restore_selected_defaults
);

  localparam CW = 16;
  localparam [CW-1:0] PULSE = RST_PULSE_CYCLES[CW-1:0];

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_PTR  = 5'h04;
  localparam [4:0] ST_WR   = 5'h08;
  localparam [4:0] ST_RD   = 5'h10;

  reg  [4:0]    state;
  reg  [3:0]    bitcnt;
  reg  [7:0]    shreg;
  reg  [7:0]    txbyte;
  reg  [7:0]    ptr;
  reg           in_ack;
  reg           rw;
  reg           mack;
  reg           scl_d;
  reg           sda_d;
  reg           wr_en;
  reg  [7:0]    wr_addr;
  reg  [7:0]    wr_data;
  reg  [6:0]    addr_field;
  reg           addr_sel;
  reg  [6:0]    strap_addr;
  reg           strap_done;
  wire [2:0]    rst_busy;
  wire [2:0]    rst_start;
  wire [7:0]    rst_value;
  wire [7:0]    rd_now;

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;

  wire start_cond = scl && scl_d && sda_d && !sda_in;
  wire stop_cond  = scl && scl_d && !sda_d && sda_in;
  wire scl_rise   = scl && !scl_d;
  wire scl_fall   = !scl && scl_d;

  function [6:0] strap_value;
    input [2:0] level;
    begin
      strap_value = `STRAP_BASE_ADDR + {3'h0, level, 1'b0};
    end
  endfunction

  function [7:0] read_reg;
    input [7:0] a;
    input [6:0] field;
    input       sel;
    input [7:0] rst;
    begin
      case (a)
        `REG_SLAVE_ADDRESS_CONFIG: read_reg = {field, sel};
        `REG_SOFT_RESET_CONTROL:   read_reg = rst;
        default:                   read_reg = `UNMAPPED_READ_VALUE;
      endcase
    end
  endfunction

  assign rst_value = {3'h0, rst_busy[2], 2'h0, rst_busy[1], rst_busy[0]};
  assign rd_now    = read_reg(ptr, addr_field, addr_sel, rst_value);

  // Self-clearing reset bits: index 0 keep-registers, 1 full core, 2 video input
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_rst
      localparam integer POS = (i == 0) ? `RST_KEEP_BIT :
                               (i == 1) ? `RST_FULL_BIT : `RST_VIDEO_BIT;
      reg [CW-1:0] cnt;
      assign rst_start[i] = wr_en && (wr_addr == `REG_SOFT_RESET_CONTROL) && wr_data[POS];
      assign rst_busy[i]  = (cnt != {CW{1'b0}});
      always @(posedge clk) begin
        if (!resetn) begin
          cnt <= {CW{1'b0}};
        end else if (rst_start[i]) begin
          cnt <= PULSE;
        end else if (rst_busy[i]) begin
          cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  assign core_reset_keep_registers = rst_busy[0];
  assign full_core_reset           = rst_busy[1];
  assign video_input_reset         = rst_busy[2];

  // Register storage; the strap is sampled on the first clock after reset release
  always @(posedge clk) begin
    if (!resetn) begin
      strap_done                <= 1'b0;
      strap_addr                <= `STRAP_BASE_ADDR;
      addr_field                <= `STRAP_BASE_ADDR;
      addr_sel                  <= `ADDR_SELECT_RESET;
      restore_selected_defaults <= 1'b0;
    end else begin
      restore_selected_defaults <= rst_start[0];
      if (!strap_done) begin
        strap_done <= 1'b1;
        strap_addr <= strap_value(address_strap_pin);
        addr_field <= strap_value(address_strap_pin);
      end else if (rst_busy[1] || rst_start[1]) begin
        // Address-register writes are ignored while the full core reset holds
        addr_field <= strap_addr;
        addr_sel   <= `ADDR_SELECT_RESET;
      end else if (rst_start[0]) begin
        addr_field <= strap_addr;
      end else if (wr_en && wr_addr == `REG_SLAVE_ADDRESS_CONFIG) begin
        addr_field <= wr_data[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
        addr_sel   <= wr_data[`ADDR_SELECT_BIT];
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      active_address <= `STRAP_BASE_ADDR;
    end else begin
      active_address <= addr_sel ? addr_field : strap_addr;
    end
  end

  // I2C slave; the slave logic is left out of the full core reset so the
  // acknowledge of the very write that triggered it still completes
  always @(posedge clk) begin
    if (!resetn) begin
      state   <= ST_IDLE;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      txbyte  <= 8'h00;
      ptr     <= 8'h00;
      in_ack  <= 1'b0;
      rw      <= 1'b0;
      mack    <= 1'b0;
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      scl_d <= scl;
      sda_d <= sda_in;
      wr_en <= 1'b0;
      if (start_cond) begin
        state  <= ST_ADDR;
        bitcnt <= 4'h0;
        in_ack <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state  <= ST_IDLE;
        in_ack <= 1'b0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state == ST_RD) begin
          if (in_ack) begin
            mack <= !sda_in;
          end else begin
            bitcnt <= bitcnt + 4'h1;
          end
        end else if (!in_ack && state != ST_IDLE) begin
          shreg  <= {shreg[6:0], sda_in};
          bitcnt <= bitcnt + 4'h1;
        end
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (in_ack) begin
              in_ack <= 1'b0;
              bitcnt <= 4'h0;
              if (rw) begin
                state  <= ST_RD;
                txbyte <= rd_now;
                sda_oe <= !rd_now[7];
                ptr    <= ptr + 8'h01;
              end else begin
                state  <= ST_PTR;
                sda_oe <= 1'b0;
              end
            end else if (bitcnt == 4'h8) begin
              if (shreg[7:1] == active_address) begin
                in_ack <= 1'b1;
                sda_oe <= 1'b1;
                rw     <= shreg[0];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_PTR, ST_WR: begin
            if (in_ack) begin
              in_ack <= 1'b0;
              bitcnt <= 4'h0;
              sda_oe <= 1'b0;
              state  <= ST_WR;
            end else if (bitcnt == 4'h8) begin
              in_ack <= 1'b1;
              sda_oe <= 1'b1;
              if (state == ST_PTR) begin
                ptr <= shreg;
              end else begin
                wr_en   <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr     <= ptr + 8'h01;
              end
            end
          end
          ST_RD: begin
            if (in_ack) begin
              in_ack <= 1'b0;
              bitcnt <= 4'h0;
              if (mack) begin
                txbyte <= rd_now;
                sda_oe <= !rd_now[7];
                ptr    <= ptr + 8'h01;
              end else begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
              end
            end else if (bitcnt == 4'h8) begin
              in_ack <= 1'b1;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= !txbyte[3'd7 - bitcnt[2:0]];
            end
          end
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // serializer_id_reset

// file: rtl/serializer_id_reset_defines.vh
// Register offsets, fields, reset values and timing for the ID and reset register bank
`ifndef SERIALIZER_ID_RESET_DEFINES_VH
`define SERIALIZER_ID_RESET_DEFINES_VH

`define REG_SLAVE_ADDRESS_CONFIG 8'h00
`define REG_SOFT_RESET_CONTROL   8'h01

`define ADDR_FIELD_MSB           7
`define ADDR_FIELD_LSB           1
`define ADDR_SELECT_BIT          0
`define ADDR_SELECT_RESET        1'b0

`define RST_VIDEO_BIT            4
`define RST_FULL_BIT             1
`define RST_KEEP_BIT             0
`define RST_RESERVED_VALUE       8'h00

`define STRAP_BASE_ADDR          7'h0C
`define STRAP_LEVEL_BITS         3

`define UNMAPPED_READ_VALUE      8'h00

`define CLK_PERIOD_NS            20
`define RST_PULSE_NS             1000
`define RST_PULSE_CYCLES         ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: bench/id_reset_asserts.sv
// Port checks for the ID and soft-reset register bank
`timescale 1ns/1ps
module id_reset_asserts (
  input wire       clk,
  input wire       resetn,
  input wire [2:0] address_strap_pin,
  input wire [6:0] active_address,
  input wire       video_input_reset,
  input wire       full_core_reset,
  input wire       core_reset_keep_registers,
  input wire       restore_selected_defaults
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [6:0] strap_addr = 7'h0C + {3'h0, address_strap_pin, 1'b0};
  sequence s_keep_start; $rose(core_reset_keep_registers); endsequence
  property p_vid_iso; $rose(video_input_reset) |-> !full_core_reset && !core_reset_keep_registers;
  endproperty
  property p_vid_clr; $rose(video_input_reset) |-> ##[1:200] !video_input_reset; endproperty
  property p_full_clr; $rose(full_core_reset) |-> ##[1:200] !full_core_reset; endproperty
  property p_keep_clr; s_keep_start |-> ##[1:200] !core_reset_keep_registers; endproperty
  property p_restore; restore_selected_defaults |-> ##[0:1] core_reset_keep_registers; endproperty
  property p_one_shot; restore_selected_defaults |=> !restore_selected_defaults; endproperty
  property p_keep_strap; s_keep_start |-> ##[1:4] active_address == strap_addr; endproperty
  property p_full_strap; $rose(full_core_reset) |-> ##[1:4] active_address == strap_addr; endproperty
  a_vid_iso: assert property (p_vid_iso) else $error("video reset not alone");
  a_vid_clr: assert property (p_vid_clr) else $error("video reset stuck");
  a_full_clr: assert property (p_full_clr) else $error("full reset stuck");
  a_keep_clr: assert property (p_keep_clr) else $error("keep reset stuck");
  a_restore: assert property (p_restore) else $error("restore without reset");
  a_one_shot: assert property (p_one_shot) else $error("restore too long");
  a_keep_strap: assert property (p_keep_strap) else $error("strap not reloaded");
  a_full_strap: assert property (p_full_strap) else $error("address not reset");
endmodule // id_reset_asserts

bind serializer_id_reset id_reset_asserts id_reset_asserts_i (.clk, .resetn, .address_strap_pin,
  .active_address, .video_input_reset, .full_core_reset, .core_reset_keep_registers,
  .restore_selected_defaults);

// file: bench/i2c_host.sv
// Behavioural I2C host on the local control bus
`timescale 1ns/1ps
module i2c_host (
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  // Signals at the 3.3V level, the only one where soft resets are allowed
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task half; repeat (4) @(negedge clk); endtask
  // A one is sent by releasing SDA, so a second host can still win the bus
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b; half; scl = 1'b1; half; r = sda; scl = 1'b0;
  endtask
  task start; sda_low = 1'b0; half; scl = 1'b1; half; sda_low = 1'b1; half; scl = 1'b0; endtask
  task stop; sda_low = 1'b1; half; scl = 1'b1; half; sda_low = 1'b0; half; endtask
  // Always releases the ninth bit: single-byte reads end with a NACK
  task automatic byte_io(input [7:0] dv, output [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(dv[i], q[i]);
    bit_io(1'b1, ack);
    ack = !ack;
  endtask
  task automatic wr(input [6:0] a, input [7:0] p, input [7:0] dv, output logic ok);
    logic [7:0] q1, q2, q3;
    logic k1, k2, k3;
    start; byte_io({a, 1'b0}, q1, k1); byte_io(p, q2, k2); byte_io(dv, q3, k3); stop;
    // A bit read back unlike the one sent means another host won the bus
    ok = k1 & k2 & k3 & (q1 == {a, 1'b0}) & (q2 == p) & (q3 == dv);
  endtask
  task automatic rd(input [6:0] a, input [7:0] p, output [7:0] dv, output logic ok);
    logic k1, k2, k3, k4;
    start; byte_io({a, 1'b0}, dv, k1); byte_io(p, dv, k2);
    start; byte_io({a, 1'b1}, dv, k3); byte_io(8'hFF, dv, k4); stop;
    ok = k1 & k2 & k3;
  endtask
endmodule // i2c_host

// file: bench/tb_top.sv
// Self-checking bench for the ID and soft-reset register bank
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module tb_top;
  localparam [6:0] STRAP_ADDR = 7'h1A; // Top strap code, the boundary step
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg [2:0]   strap = 3'h7;
  wire        scl;
  wire        host_low;
  wire        sda_out;
  wire        sda_oe;
  wire        sda = !(host_low | sda_oe | sda_out);
  wire [6:0]  active_address;
  wire [2:0]  rst_vec;
  wire        restore;
  int         cnt [3];
  int         rcnt = 0;
  int         checks = 0;
  int         mismatches = 0;
  logic [7:0] d;
  logic       ok;
  always #10 clk = !clk;
  always @(posedge clk) for (int i = 0; i < 3; i++) if (rst_vec[i]) cnt[i]++;
  always @(posedge clk) if (restore) rcnt++;
  serializer_id_reset #(.RST_PULSE_CYCLES(5)) serializer_id_reset_i (.clk(clk), .resetn(resetn),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pin(strap),
    .active_address(active_address), .video_input_reset(rst_vec[2]),
    .full_core_reset(rst_vec[1]), .core_reset_keep_registers(rst_vec[0]),
    .restore_selected_defaults(restore));
  i2c_host i2c_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  task stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task t_regs;
    i2c_host_i.wr(STRAP_ADDR, 8'h16, 8'h02, ok); // First init write, not mapped here
    `CHK(ok, 1'b1)
    `CHK(sda_out, 1'b0)
    `CHK(active_address, STRAP_ADDR)
    i2c_host_i.rd(STRAP_ADDR, 8'h00, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, {STRAP_ADDR, 1'b0})
    i2c_host_i.wr(STRAP_ADDR, 8'h01, 8'hEC, ok);
    i2c_host_i.rd(STRAP_ADDR, 8'h01, d, ok);
    `CHK(d, 8'h00)
    i2c_host_i.rd(STRAP_ADDR, 8'h16, d, ok);
    `CHK(d, 8'h00)
    $display("t_regs done");
  endtask
  task t_select;
    i2c_host_i.wr(STRAP_ADDR, 8'h00, 8'hD5, ok); // New address has several ones
    `CHK(active_address, 7'h6A)
    i2c_host_i.rd(7'h6A, 8'h00, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, 8'hD5)
    i2c_host_i.rd(STRAP_ADDR, 8'h00, d, ok);
    `CHK(ok, 1'b0)
    $display("t_select done");
  endtask
  // Pulses end before the stop, so the counters run beside the transfer
  task t_pulse(input [2:0] sel, input [7:0] v, input [6:0] a, input [6:0] b, input [7:0] e);
    cnt = '{0, 0, 0};
    rcnt = 0;
    i2c_host_i.wr(a, 8'h01, v, ok);
    `CHK(ok, 1'b1)
    `CHK(rcnt, (sel == 3'b001) ? 1 : 0)
    `CHK({cnt[2] == 5, cnt[1] == 5, cnt[0] == 5}, sel)
    `CHK(cnt[0] + cnt[1] + cnt[2], 5)
    i2c_host_i.rd(b, 8'h00, d, ok);
    `CHK(d, e)
    i2c_host_i.rd(b, 8'h01, d, ok);
    `CHK(d, 8'h00)
    $display("t_pulse %h done", v);
  endtask
  // Mid-run reset with the lowest strap code; the strap is only read just after release
  task t_strap;
    strap = 3'h0;
    resetn = 1'b0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(active_address, 7'h0C)
    i2c_host_i.rd(7'h0C, 8'h00, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, 8'h18)
    $display("t_strap done");
  endtask
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_regs;
    t_select;
    t_pulse(3'b100, 8'h10, 7'h6A, 7'h6A, 8'hD5);
    t_pulse(3'b001, 8'h01, 7'h6A, STRAP_ADDR, {STRAP_ADDR, 1'b1});
    t_pulse(3'b010, 8'h02, STRAP_ADDR, STRAP_ADDR, {STRAP_ADDR, 1'b0});
    i2c_host_i.wr(STRAP_ADDR, 8'h4F, 8'h02, ok); // Bridge control reload request
    t_strap;
    stop_test;
  end
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    stop_test;
  end
endmodule // tb_top
